// [hw/spr_serial_poll.sv]
// Purpose: Serial poll response and service request logic of a
//          bus non-controller, with an AHB-Lite register slave.
// Assumes: Talker state inputs come from logic on clk_i.
// Notes:   Zero wait state slave, response always OKAY.
// Function
// RULE1 - Status write register keeps bit 8 at 7, bits 6..1 at 5..0.
// RULE2 - Mode one: software always writes request-service bit as zero.
// RULE3 - Mode two: written request-service bit is returned as RQS.
// RULE4 - Mode three: writing request-service bit set asserts SRQ.
// RULE5 - Readback returns last written status bits in same positions; code returns the pending flag at bit 6 instead.
// RULE6 - Pending flag sets when service is requested per mode.
// RULE7 - Pending flag clears when the controller polls the device.
// RULE8 - Address status bit 5 shows poll mode state; send needs TA.
// RULE9 - Mode one: poll answered at once with current status byte.
// RULE10 - Mode two: interrupt, hold off until status write, send it.
// RULE11 - Software picks mode two by the status out interrupt enable.
// RULE12 - Mode one: request-true then status write asserts SRQ.
// RULE13 - Mode one: SRQ holds until polled or withdrawn.
// RULE14 - Mode one: request-false then status write drops SRQ.
// RULE15 - Mode one: plain status write leaves SRQ unchanged.
// RULE16 - Mode two: request-true asserts SRQ until poll or false.
// RULE17 - Mode two: poll sets status out flag.
// RULE18 - Mode two: software sets request bit only when requesting.
// RULE19 - Mode three: SRQ holds until poll; clear write drops it.
// RULE20 - Response byte: bit 8 at 7, RQS at 6, bits 6..1 at 5..0.
// RULE21 - Modes one, three: RQS from own request; two: written bit.
// RULE22 - Status out flag sets on poll entry, clears on write or exit.
// RULE23 - Request-false command deasserts SRQ; code drops SRQ on it only in mode two.
// RULE24 - End on poll option sends EOI with every response byte.
// RULE25 - Response byte is one coherent value during a poll.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "spr_regs.svh"

module spr_serial_poll (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire spr_pkg::spr_ahb_req_t ahb_req_i,
  output spr_pkg::spr_ahb_rsp_t ahb_rsp_o,
  // Talker state
  input wire logic serial_poll_mode_state_i,
  input wire logic talker_active_i,
  input wire logic poll_byte_taken_i,
  // Bus side answer
  output logic srq_o,
  output logic resp_valid_o,
  output logic [7:0] resp_byte_o,
  output logic resp_eoi_o,
  output logic status_out_irq_o
);
  import spr_pkg::*;

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // Mode from the interrupt enable and the mode three select
  function automatic spr_mode_t spr_mode(input logic irq_en,
                                         input logic m3);
    spr_mode_t m;
    m = SPR_MODE_ONE;
    if (irq_en) begin
      m = SPR_MODE_TWO;
    end else if (m3) begin
      m = SPR_MODE_THREE;
    end
    return m;
  endfunction

  // Read data for one byte address
  function automatic logic [31:0] spr_read(input spr_state_t st,
                                           input logic [7:0] a,
                                           input logic serial_poll_mode_state,
                                           input logic ta);
    logic [31:0] r;
    r = `SPR_RST_WORD;
    case (a)
      `SPR_ADDR_STATUS: begin
        r[7:0] = st.stb;
        r[`SPR_BIT_PENDING_SERVICE_REQUEST] = st.pending_service_request;
      end
      `SPR_ADDR_ADDRST: begin
        r[`SPR_BIT_SERIAL_POLL_MODE_STATE] = serial_poll_mode_state;
        r[`SPR_BIT_TA] = ta;
      end
      `SPR_ADDR_IRQ0: begin
        r[`SPR_BIT_STATUS_OUT_FLAG] = st.flag;
      end
      `SPR_ADDR_CONFIG: begin
        r[`SPR_BIT_EOP] = st.cfg_eop;
        r[`SPR_BIT_MODE3] = st.cfg_m3;
      end
      default: begin
        r = `SPR_RST_WORD;
      end
    endcase
    return r;
  endfunction

  // ************************************************************
  // State and decoded events
  // ************************************************************
  spr_state_t s_q;
  spr_state_t s_d;
  spr_mode_t mode;
  logic serial_poll_active_state;
  logic serial_poll_active_state_rise;
  logic serial_poll_active_state_fall;
  logic ap_take;
  logic wr_now;
  logic sbw;
  logic aux;
  logic reqt;
  logic reqf;
  logic [7:0] wdata;
  logic sent;

  // Event decode from the bus data phase and the talker
  always_comb begin
    mode = spr_mode(s_q.irq_en, s_q.cfg_m3);
    serial_poll_active_state = serial_poll_mode_state_i & talker_active_i; // RULE8
    serial_poll_active_state_rise = serial_poll_active_state & ~s_q.serial_poll_active_state;
    serial_poll_active_state_fall = ~serial_poll_active_state & s_q.serial_poll_active_state;
    ap_take = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
    wr_now = s_q.ap_wr & s_q.ap_hit;
    wdata = ahb_req_i.hwdata[7:0];
    sbw = wr_now & (s_q.ap_addr == `SPR_ADDR_STATUS);
    aux = wr_now & (s_q.ap_addr == `SPR_ADDR_AUXCMD);
    reqt = aux & (wdata == `SPR_CMD_REQT);
    reqf = aux & (wdata == `SPR_CMD_REQF);
    sent = poll_byte_taken_i & s_q.resp_vld & serial_poll_active_state;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.serial_poll_active_state = serial_poll_active_state;

    // Bus address phase, read data fetched early
    s_d.ap_wr = 1'b0;
    if (ap_take) begin
      s_d.ap_wr = ahb_req_i.hwrite;
      s_d.ap_addr = ahb_req_i.haddr[7:0];
      s_d.ap_hit = (ahb_req_i.haddr[31:8] == 24'h00_0000);
      s_d.rdata = `SPR_RST_WORD;
      if (!ahb_req_i.hwrite && s_d.ap_hit) begin
        s_d.rdata = spr_read(s_q, ahb_req_i.haddr[7:0],
                             serial_poll_mode_state_i,
                             talker_active_i); // RULE5 RULE8
      end
    end

    // Register writes that only store a value
    if (sbw) begin
      s_d.stb = wdata; // RULE1
    end
    if (wr_now && s_q.ap_addr == `SPR_ADDR_IRQ0) begin
      s_d.irq_en = wdata[`SPR_BIT_STATUS_OUT_FLAG];
    end
    if (wr_now && s_q.ap_addr == `SPR_ADDR_CONFIG) begin
      s_d.cfg_eop = wdata[`SPR_BIT_EOP];
      s_d.cfg_m3 = wdata[`SPR_BIT_MODE3];
    end

    // A finished poll whose byte carried RQS withdraws the request first
    if (sent && s_q.resp[`SPR_BIT_RSV]) begin
      s_d.srq = 1'b0; // RULE13 RULE19
      s_d.req = 1'b0;
    end
    if (sent) begin
      s_d.pending_service_request = 1'b0; // RULE7
    end

    // Request commands, latched for mode one
    if (reqt) begin
      s_d.req = 1'b1;
    end
    if (reqf) begin
      s_d.req = 1'b0;
    end

    // Service request line per mode, sets win over poll clear
    unique case (mode)
      SPR_MODE_ONE: begin
        if (sbw) begin
          s_d.srq = s_q.req; // RULE12 RULE14 RULE15
        end
      end
      SPR_MODE_TWO: begin
        if (reqt) begin
          s_d.srq = 1'b1; // RULE16
        end
        if (reqf) begin
          s_d.srq = 1'b0; // RULE23
        end
      end
      SPR_MODE_THREE: begin
        if (sbw) begin
          s_d.srq = wdata[`SPR_BIT_RSV]; // RULE4 RULE19
        end
      end
    endcase

    // Pending flag sets on a request in modes one and two, never in mode three
    if (reqt && mode != SPR_MODE_THREE) begin
      s_d.pending_service_request = 1'b1; // RULE6
    end
    if (sbw && wdata[`SPR_BIT_RSV] && mode == SPR_MODE_TWO) begin
      s_d.pending_service_request = 1'b1; // RULE6
    end

    // Status out flag, set wins over clear
    if (sbw || serial_poll_active_state_fall) begin
      s_d.flag = 1'b0; // RULE22
    end
    if (serial_poll_active_state_rise) begin
      s_d.flag = 1'b1; // RULE17 RULE22
    end

    // Response byte, frozen once loaded
    if (!serial_poll_active_state || sent) begin
      s_d.resp_vld = 1'b0;
    end
    if (serial_poll_active_state_rise && mode != SPR_MODE_TWO) begin
      s_d.resp = {s_q.stb[`SPR_BIT_STB8], s_q.srq,
                  s_q.stb[5:0]}; // RULE9 RULE20 RULE21 RULE25
      s_d.resp_vld = 1'b1;
      s_d.resp_eoi = s_q.cfg_eop; // RULE24
    end
    if (sbw && serial_poll_active_state && !s_q.resp_vld && mode == SPR_MODE_TWO) begin
      s_d.resp = wdata; // RULE3 RULE10 RULE21
      s_d.resp_vld = 1'b1;
      s_d.resp_eoi = s_q.cfg_eop; // RULE24
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.stb <= `SPR_RST_STATUS;
      s_q.resp <= `SPR_RST_BYTE;
      s_q.rdata <= `SPR_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ahb_rsp_o.hrdata = s_q.rdata;
  assign ahb_rsp_o.hreadyout = 1'b1;
  assign ahb_rsp_o.hresp = 1'b0;
  assign srq_o = s_q.srq;
  assign resp_valid_o = s_q.resp_vld & serial_poll_active_state; // RULE8
  assign resp_byte_o = s_q.resp;
  assign resp_eoi_o = s_q.resp_eoi;
  assign status_out_irq_o = s_q.flag & s_q.irq_en; // RULE10

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_poll_start;
    serial_poll_active_state_rise;
  endsequence

  sequence seq_status_write;
    sbw && !sent;
  endsequence

  sequence seq_poll_rqs;
    sent && s_q.resp[`SPR_BIT_RSV];
  endsequence

  chk_status_store: assert property ( // RULE1
    sbw |=> s_q.stb == $past(wdata))
    else $error("status byte not stored");

  chk_readback_word: assert property ( // RULE5
    (ap_take && !ahb_req_i.hwrite &&
     ahb_req_i.haddr == 32'h0000_0018)
    |=> ahb_rsp_o.hrdata[7:0] ==
        {$past(s_q.stb[7]), $past(s_q.pending_service_request), $past(s_q.stb[5:0])})
    else $error("readback word wrong");

  chk_mode_two_rqs: assert property ( // RULE3
    (sbw && serial_poll_active_state && !s_q.resp_vld && mode == SPR_MODE_TWO)
    |=> resp_byte_o == $past(wdata) && s_q.resp_vld)
    else $error("mode two response not loaded");

  chk_mode_three_srq: assert property ( // RULE4
    (seq_status_write and mode == SPR_MODE_THREE)
    |=> srq_o == $past(wdata[6]))
    else $error("mode three srq wrong");

  chk_pending_service_request_clear: assert property ( // RULE7
    (sent && !reqt && !(sbw && wdata[6])) |=> !s_q.pending_service_request)
    else $error("pending not cleared by poll");

  chk_mode_one_now: assert property ( // RULE9
    (seq_poll_start and mode == SPR_MODE_ONE)
    |=> s_q.resp_vld && resp_byte_o[6] == $past(s_q.srq))
    else $error("mode one poll not answered");

  chk_mode_two_hold: assert property ( // RULE10
    (mode == SPR_MODE_TWO && serial_poll_active_state && !s_q.resp_vld && !sbw)
    |=> !s_q.resp_vld)
    else $error("mode two sent without write");

  chk_flag_set: assert property ( // RULE22
    seq_poll_start |=> s_q.flag ##1 (s_q.flag || !serial_poll_active_state || sbw ||
                                     $past(sbw)))
    else $error("status out flag not set");

  chk_reqf_drop: assert property ( // RULE23
    (reqf && mode == SPR_MODE_TWO) |=> !srq_o)
    else $error("request false kept srq");

  chk_mode_one_write: assert property ( // RULE15
    (seq_status_write and mode == SPR_MODE_ONE)
    |=> srq_o == $past(s_q.req))
    else $error("mode one write srq wrong");

  chk_eoi_capture: assert property ( // RULE24
    $rose(s_q.resp_vld) |-> resp_eoi_o == $past(s_q.cfg_eop))
    else $error("eoi not captured");

  chk_resp_stable: assert property ( // RULE25
    (s_q.resp_vld && serial_poll_active_state) |=> (s_q.resp_vld |-> $stable(resp_byte_o)))
    else $error("response changed mid poll");

  chk_pending_service_request_set: assert property ( // RULE6
    (reqt && mode != SPR_MODE_THREE) |=> s_q.pending_service_request)
    else $error("pending not set by request");

  chk_poll_srq_drop: assert property ( // RULE13
    (seq_poll_rqs and (!sbw && !reqt)) |=> !srq_o)
    else $error("srq kept after poll");

  chk_mode_two_reqt: assert property ( // RULE16
    (reqt && mode == SPR_MODE_TWO) |=> srq_o)
    else $error("request true did not raise srq");

  chk_reqf_one_hold: assert property ( // RULE14
    (reqf && mode == SPR_MODE_ONE && !sent) |=> $stable(srq_o))
    else $error("mode one request false moved srq early");

  chk_flag_clear: assert property ( // RULE22
    ((sbw || serial_poll_active_state_fall) && !serial_poll_active_state_rise) |=> !s_q.flag)
    else $error("status out flag not cleared");

  chk_mode_two_irq: assert property ( // RULE17
    (seq_poll_start and (mode == SPR_MODE_TWO && !wr_now))
    |=> status_out_irq_o)
    else $error("mode two poll raised no interrupt");

  chk_mode_three_now: assert property ( // RULE21
    (seq_poll_start and mode == SPR_MODE_THREE)
    |=> s_q.resp_vld && resp_byte_o[6] == $past(s_q.srq))
    else $error("mode three poll not answered");

  chk_resp_layout: assert property ( // RULE20
    (seq_poll_start and mode != SPR_MODE_TWO)
    |=> {resp_byte_o[7], resp_byte_o[5:0]} ==
        $past({s_q.stb[7], s_q.stb[5:0]}))
    else $error("response byte layout wrong");

endmodule

`default_nettype wire

// [hw/spr_regs.svh]
// Purpose: Register map, field positions and command codes of the
//          serial poll response manager.
// Assumes: Byte addresses are four times the register index.
// Notes:   Definitions only.
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// ************************************************************
// Register indices and byte addresses
// ************************************************************
`define SPR_IDX_STATUS 6'h06
`define SPR_IDX_ADDRST 6'h08
`define SPR_IDX_AUXCMD 6'h0A
`define SPR_IDX_IRQ0 6'h1D
`define SPR_IDX_CONFIG 6'h20
`define SPR_ADDR_STATUS {`SPR_IDX_STATUS, 2'b00}
`define SPR_ADDR_ADDRST {`SPR_IDX_ADDRST, 2'b00}
`define SPR_ADDR_AUXCMD {`SPR_IDX_AUXCMD, 2'b00}
`define SPR_ADDR_IRQ0 {`SPR_IDX_IRQ0, 2'b00}
`define SPR_ADDR_CONFIG {`SPR_IDX_CONFIG, 2'b00}

// ************************************************************
// Field positions
// ************************************************************
`define SPR_BIT_STB8 7
`define SPR_BIT_RSV 6
`define SPR_BIT_PENDING_SERVICE_REQUEST 6
`define SPR_BIT_SERIAL_POLL_MODE_STATE 5
`define SPR_BIT_TA 1
`define SPR_BIT_STATUS_OUT_FLAG 6
`define SPR_BIT_EOP 0
`define SPR_BIT_MODE3 1

// ************************************************************
// Reset values and auxiliary commands
// ************************************************************
`define SPR_RST_STATUS 8'h00
`define SPR_RST_BYTE 8'h00
`define SPR_RST_WORD 32'h0000_0000
`define SPR_CMD_REQT 8'h18
`define SPR_CMD_REQF 8'h19

`endif

// [hw/spr_pkg.sv]
// Purpose: Types of the serial poll response manager.
// Assumes: Constants come from spr_regs.svh.
// Notes:   All state of the block lives in spr_state_t.
package spr_pkg;

  // ************************************************************
  // Serial poll modes, Gray coded
  // ************************************************************
  typedef enum logic [1:0] {
    SPR_MODE_ONE = 2'b00,
    SPR_MODE_TWO = 2'b01,
    SPR_MODE_THREE = 2'b11
  } spr_mode_t;

  // ************************************************************
  // AHB-Lite request and answer groups
  // ************************************************************
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } spr_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } spr_ahb_rsp_t;

  // ************************************************************
  // Whole state of the block
  // ************************************************************
  typedef struct packed {
    logic ap_wr;
    logic ap_hit;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [7:0] stb;
    logic req;
    logic srq;
    logic pending_service_request;
    logic flag;
    logic irq_en;
    logic cfg_eop;
    logic cfg_m3;
    logic serial_poll_active_state;
    logic [7:0] resp;
    logic resp_vld;
    logic resp_eoi;
  } spr_state_t;

endpackage

// [sim/spr_poll_ctrl.sv]
// Purpose: Bus controller model that serially polls the device.
// Assumes: One poll at a time, begun by a one-cycle start pulse.
// Notes:   slow_i adds cycles between byte valid and byte taken.
`timescale 1ns/1ns
`default_nettype none

module spr_poll_ctrl (
  // Clock and control
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [3:0] slow_i,
  // Device answer
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_byte_i,
  input wire logic resp_eoi_i,
  // Poll state and result
  output logic mode_st_o,
  output logic talk_act_o,
  output logic taken_o,
  output logic done_o,
  output logic [7:0] byte_o,
  output logic eoi_o
);
  // Idle at time zero, then one serial poll per start pulse;
  // a single process so every output has one driver
  initial begin
    mode_st_o = 1'b0;
    talk_act_o = 1'b0;
    taken_o = 1'b0;
    done_o = 1'b0;
    byte_o = 8'h00;
    eoi_o = 1'b0;
    forever begin
      @(posedge clk_i);
      done_o <= 1'b0;
      if (start_i === 1'b1) begin
        mode_st_o <= 1'b1;
        talk_act_o <= 1'b1;
        do @(posedge clk_i); while (resp_valid_i !== 1'b1);
        repeat (slow_i) @(posedge clk_i);
        byte_o <= resp_byte_i;
        eoi_o <= resp_eoi_i;
        taken_o <= 1'b1;
        @(posedge clk_i);
        taken_o <= 1'b0;
        mode_st_o <= 1'b0;
        talk_act_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/spr_tb.sv]
// Purpose: Self-checking bench of the serial poll response manager.
// Assumes: The partner model plays the polling bus controller.
// Notes:   Reads and polls are checked by watchers against queues.
`timescale 1ns/1ns
`default_nettype none
`include "spr_regs.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, a); end end

module testbench;
  import spr_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk_i, rst_i, start, p_done, p_taken, p_eoi, mode_st, talk_act;
  logic srq, vld, eoi, irq;
  logic [3:0] slow;
  logic [7:0] p_byte, b, rbyte;
  logic [8:0] exp_p;
  logic [31:0] rd_val, exp_r;
  logic [31:0] rq[$];
  logic [8:0] pq[$];
  int error_cnt, samples_checked, seed;
  event rd_ev;
  spr_ahb_req_t req, bus;
  spr_ahb_rsp_t rsp;

  // ************************************************************
  // Design, partner and clock
  // ************************************************************
  spr_serial_poll uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ahb_req_i(bus),
    .ahb_rsp_o(rsp),
    .serial_poll_mode_state_i(mode_st),
    .talker_active_i(talk_act),
    .poll_byte_taken_i(p_taken),
    .srq_o(srq),
    .resp_valid_o(vld),
    .resp_byte_o(rbyte),
    .resp_eoi_o(eoi),
    .status_out_irq_o(irq)
  );
  spr_poll_ctrl ctrl (
    .clk_i(clk_i),
    .start_i(start),
    .slow_i(slow),
    .resp_valid_i(vld),
    .resp_byte_i(rbyte),
    .resp_eoi_i(eoi),
    .mode_st_o(mode_st),
    .talk_act_o(talk_act),
    .taken_o(p_taken),
    .done_o(p_done),
    .byte_o(p_byte),
    .eoi_o(p_eoi)
  );
  // Single slave: its hreadyout is the bus hready
  always_comb begin
    bus = req;
    bus.hready = rsp.hreadyout;
  end
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ************************************************************
  // Bus and poll tasks
  // ************************************************************
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr <= {24'h00_0000, a};
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= {24'h00_0000, d};
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    rd_val = rsp.hrdata;
  endtask
  // Write, then one idle cycle so the effect has landed
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    xfer(1'b0, a, 8'h00);
    -> rd_ev;
  endtask
  task poll(input logic [8:0] e, input logic [3:0] s);
    pq.push_back(e);
    slow <= s;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask
  task wdone;
    for (int n = 0; n < 100 && p_done !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task cs(input logic e);
    `CHK("srq", e, srq)
  endtask
  task results;
    error_cnt += pq.size() + rq.size(); // Notes never answered
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Watchers
  // ************************************************************
  // Read data against the oldest noted read
  always @(rd_ev) begin
    exp_r = rq.pop_front();
    `CHK("hrdata", exp_r, rd_val)
    `CHK("hresp", 1'b0, rsp.hresp)
  end
  // Poll byte and EOI against the oldest noted poll
  always @(posedge clk_i) begin
    if (p_done === 1'b1) begin
      exp_p = pq.pop_front();
      `CHK("poll", exp_p, {p_eoi, p_byte})
    end
  end
  // Hang guard, about 20000 cycles
  initial begin
    #200000;
    error_cnt++;
    results;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 73;
    error_cnt = 0;
    samples_checked = 0;
    req = '0;
    start = 1'b0;
    slow = 4'h0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`SPR_ADDR_STATUS, 32'h0000_0000);
    rd(`SPR_ADDR_ADDRST, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    // Mode one: plain write, then request, then withdraw
    b = 8'($random(seed));
    b[6] = 1'b0;
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b0);
    rd(`SPR_ADDR_STATUS, {24'h00_0000, b});
    poll({1'b0, b}, 4'h0);
    wdone;
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQT);
    cs(1'b0);
    rd(`SPR_ADDR_STATUS, {24'h00_0000, b | 8'h40});
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b1);
    poll({1'b0, b | 8'h40}, 4'h5);
    wdone;
    cs(1'b0);
    rd(`SPR_ADDR_STATUS, {24'h00_0000, b});
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQT);
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b1);
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQF);
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b0);
    // Mode two: request, held-off poll answered by a status write
    wr(`SPR_ADDR_IRQ0, 8'h40);
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQT);
    cs(1'b1);
    b = 8'($random(seed));
    b[6] = 1'b1;
    poll({1'b0, b}, 4'h2);
    for (int n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    `CHK("valid", 1'b0, vld)
    rd(`SPR_ADDR_ADDRST, 32'h0000_0022);
    rd(`SPR_ADDR_IRQ0, 32'h0000_0040);
    wr(`SPR_ADDR_STATUS, b);
    `CHK("irq", 1'b0, irq)
    wdone;
    cs(1'b0);
    rd(`SPR_ADDR_STATUS, {24'h00_0000, b & 8'hBF});
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQT);
    cs(1'b1);
    wr(`SPR_ADDR_AUXCMD, `SPR_CMD_REQF);
    cs(1'b0);
    wr(`SPR_ADDR_IRQ0, 8'h00);
    // Mode three with EOI on every response byte
    wr(`SPR_ADDR_CONFIG, 8'h03);
    b = 8'($random(seed));
    b[6] = 1'b1;
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b1);
    poll({1'b1, b}, 4'h0);
    wdone;
    cs(1'b0);
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b1);
    b[6] = 1'b0;
    wr(`SPR_ADDR_STATUS, b);
    cs(1'b0);
    // A write during a slow poll must not touch the byte on the bus
    poll({1'b1, b}, 4'h8);
    for (int n = 0; n < 50 && vld !== 1'b1; n++) @(posedge clk_i);
    wr(`SPR_ADDR_STATUS, b ^ 8'h3F);
    wdone;
    results;
  end
endmodule
`default_nettype wire
